// ==== logic/ssp_pkg.sv ====
/*
  Shared constants for the storage select and prefix decode block:
  register offsets and fields, storage address field positions, timing
  and the one-hot state encoding. Assumes a 100 MHz aclk and 32-bit
  AXI4-Lite register access.
*/
package ssp_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int UNITS    = 8;
  localparam int AW       = 24;
  localparam int CODE_W   = 3;
  localparam int CHANS    = 4;
  localparam int REG_AW   = 8;
  localparam int SYNC_W   = 64;

  // ************************************************************
  // Register map, byte addresses and fields
  // ************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam int CTRL_PREFIX_SW = 0;
  localparam int CTRL_EXPAND    = 1;
  localparam int CTRL_LOAD      = 2;
  localparam int CTRL_RESTART   = 3;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Storage address fields; address bit 0 is the most significant.
  // ************************************************************
  localparam int A_HI_TOP   = 23;
  localparam int A_HI_BOT   = 21;
  localparam int A_UNIT_TOP = 20;
  localparam int A_UNIT_BOT = 18;
  localparam int A_BIT6     = 17;
  localparam int A_BIT20    = 3;
  localparam logic [23:0] BLK_MASK = 24'hfff000;
  localparam logic [23:0] FWD_ONES = 24'h03f000;
  localparam logic [23:0] UNIT_MSK = 24'h1c0000;
  localparam logic [2:0]  BIG_CODE = 3'h4;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_NS       = 10;
  localparam int ACC_DELAY_NS = 25;
  localparam int ACC_DELAY_CYC = (ACC_DELAY_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [4:0] {
    S_IDLE   = 5'h01,
    S_DECODE = 5'h02,
    S_RETRY  = 5'h04,
    S_WAIT   = 5'h08,
    S_CLEAN  = 5'h10
  } ssp_state_t;

endpackage

// ==== logic/ssp_select.sv ====
/*
  Storage selection with floating addressing and prefix relocation,
  plus an AXI4-Lite register slave for panel settings and status.
  Assumes requests arrive on aclk; all storage-unit pins are asynchronous
  and are resynchronised here.
*/
// Function
// - Compare bits 3-5 with each unit code; select available matches only.
// - CPU address is an OR of three gated sources; channel overrides it.
// - Bits 6 and 20 choose the even or odd interleaved half.
// - Channel requests decode straight from the storage address bus.
// - Prefix on: flag CPU first block, channel first block, CPU last block.
// - No detector firing on a valid request means the first pulse selects the decoded unit.
// - A detector hit withholds the pulse and sets a relocation latch.
// - Forward latch puts prefix bits on 3-5 and ones on 6-11.
// - Backward latch zeroes bits 0-11 of processor addresses only.
// - Latches set any-relocation; detectors stop; next pulse selects.
// - Duplicate codes or units above 1048 K without expansion: invalid.
// - Requested unit unallocated, in test or unpowered is invalid.
// - No matching unit or address bits 0-2 nonzero is invalid.
// - Invalid request: second pulse plus cancel to lowest powered unit.
// - Relocation retries never count as invalid and never cancel.
// - Select goes even to busy units; cleanup waits for accept.
// - Late accept raises oscillator inhibit, held until accept arrives.
// - Bus cleanup comes only when the accept latch sets.
// - Accept delayed 25 ns grants the lowest-numbered pending channel.
// - Relocation adds a cycle; only CPU requests stop the CPU clock once.
// - Unit codes are three-bit binary, first position 000.
// - Detectors need the enable flag, sampled at load, restart, power on.
`timescale 1ns/1ps
module ssp_select (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [7:0]                     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [7:0]                     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic                           cpu_req,
  input  wire logic [2:0]                     cpu_gate,
  input  wire logic [23:0]                    cpu_src_data,
  input  wire logic [23:0]                    instruction_counter_source,
  input  wire logic [23:0]                    alternate_address_source,
  input  wire logic                           chan_req,
  input  wire logic [23:0]                    chan_addr,
  input  wire logic [4:0][2:0]                unused_dummy_never,
  input  wire logic [23:0]                    unit_code,
  input  wire logic [7:0]                     unit_alloc,
  input  wire logic [7:0]                     unit_power,
  input  wire logic [7:0]                     unit_test,
  input  wire logic [7:0]                     unit_accept,
  input  wire logic                           dup_detect,
  input  wire logic [2:0]                     float_prefix,
  input  wire logic [3:0]                     chan_sync,
  output logic [7:0]                          select_even,
  output logic [7:0]                          select_odd,
  output logic                                select_cancel,
  output logic [23:0]                         storage_address_bus,
  output logic                                osc_inhibit,
  output logic                                cpu_clock_stop,
  output logic                                bus_cleanup,
  output logic [3:0]                          chan_grant
);

  // ************************************************************
  // Helper functions
  // ************************************************************
  // Lowest set bit as a one-hot mask; lowest index wins.
  function automatic logic [7:0] lowest_one(input logic [7:0] v);
    logic [7:0] r;
    r = v & (~v + 8'h01);
    return r;
  endfunction

  function automatic logic [2:0] unit_of(input logic [23:0] a);
    return a[ssp_pkg::A_UNIT_TOP:ssp_pkg::A_UNIT_BOT];
  endfunction

  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  logic [ssp_pkg::SYNC_W-1:0] sync1;
  logic [ssp_pkg::SYNC_W-1:0] sync2;

  // Every storage-unit pin passes two flops before anything looks at it.
  always_ff @(posedge aclk) begin
    sync1 <= {unit_code, unit_alloc, unit_power, unit_test, unit_accept,
              dup_detect, float_prefix, chan_sync};
    sync2 <= sync1;
  end

  wire [23:0] code_s   = sync2[63:40];
  wire [7:0]  alloc_s  = sync2[39:32];
  wire [7:0]  power_s  = sync2[31:24];
  wire [7:0]  test_s   = sync2[23:16];
  wire [7:0]  accept_s = sync2[15:8];
  wire        dup_s    = sync2[7];
  wire [2:0]  fpref_s  = sync2[6:4];
  wire [3:0]  csync_s  = sync2[3:0];

  // ************************************************************
  // Request state
  // ************************************************************
  ssp_pkg::ssp_state_t st;
  ssp_pkg::ssp_state_t next_st;
  logic        chan_pri;
  logic [23:0] cpu_q;
  logic [23:0] chan_q;
  logic        fwd;
  logic        bwd;
  logic        any_reloc;
  logic        cancel_pend;
  logic        wait_first;
  logic [7:0]  sel_mask;
  logic        enable_prefix;
  logic        pwr_done;
  logic [1:0]  ctrl;
  logic [ssp_pkg::ACC_DELAY_CYC-1:0] acc_dly;

  // ************************************************************
  // Address merge and relocation
  // ************************************************************
  // Gated OR of the three processor sources.
  wire [23:0] cpu_or = ({24{cpu_gate[0]}} & cpu_src_data)
                     | ({24{cpu_gate[1]}} & instruction_counter_source)
                     | ({24{cpu_gate[2]}} & alternate_address_source);
  // Backward relocation blocks the processor sources only.
  wire [23:0] cpu_m = bwd ? (cpu_q & ~ssp_pkg::BLK_MASK) : cpu_q;
  // Channel bits come straight off the bus; no degating possible.
  wire [23:0] raw_addr = chan_pri ? chan_q : cpu_m;
  // Forward relocation substitutes prefix bits and forces bits 6-11.
  wire [23:0] fwd_addr = (raw_addr & ~(ssp_pkg::UNIT_MSK | ssp_pkg::FWD_ONES))
                       | ssp_pkg::FWD_ONES
                       | {3'h0, fpref_s, 18'h0};
  wire [23:0] comb_addr = fwd ? fwd_addr : raw_addr;
  wire [2:0]  ufield    = unit_of(comb_addr);

  // ************************************************************
  // Unit comparison and validity
  // ************************************************************
  wire [7:0] match;
  wire [7:0] big;
  wire [7:0] avail = alloc_s & power_s & ~test_s;
  genvar gi;
  // Binary-coded unit positions compared with bits 3-5.
  for (gi = 0; gi < ssp_pkg::UNITS; gi = gi + 1) begin : g_unit
    assign match[gi] = (code_s[gi*3 +: 3] == ufield);
    assign big[gi]   = (code_s[gi*3 +: 3] >= ssp_pkg::BIG_CODE);
  end
  wire [7:0] hit         = match & avail;
  wire [7:0] first_avail = lowest_one(power_s);
  // Configuration faults block decoding whichever unit is asked.
  wire bad_cfg = dup_s | (~ctrl[ssp_pkg::CTRL_EXPAND] & |(alloc_s & big));
  wire hi_bits = |comb_addr[ssp_pkg::A_HI_TOP:ssp_pkg::A_HI_BOT];
  // Unmatched, unavailable or too-high addresses are invalid.
  wire req_bad = bad_cfg | hi_bits | ~|hit;
  // Interleave choice from bits 6 and 20.
  wire odd = comb_addr[ssp_pkg::A_BIT6] ^ comb_addr[ssp_pkg::A_BIT20];

  // ************************************************************
  // Prefix detectors
  // ************************************************************
  // Detectors work only with the enable flag and no relocation yet.
  wire det_en    = enable_prefix & ~any_reloc;
  wire first_blk = ~|(comb_addr & ssp_pkg::BLK_MASK);
  wire last_blk  = ~hi_bits & (ufield == fpref_s)
                 & ((comb_addr & ssp_pkg::FWD_ONES) == ssp_pkg::FWD_ONES);
  wire det_fwd   = det_en & first_blk;
  wire det_bwd   = det_en & ~chan_pri & last_blk;
  wire det_any   = det_fwd | det_bwd;

  // ************************************************************
  // Select issue
  // ************************************************************
  wire in_dec     = (st == ssp_pkg::S_DECODE);
  wire in_retry   = (st == ssp_pkg::S_RETRY);
  wire in_wait    = (st == ssp_pkg::S_WAIT);
  // First pulse goes out only when no detector fires.
  wire issue      = (in_dec & ~det_any & ~req_bad) | in_retry;
  // An invalid retry goes to the first powered unit with cancel.
  wire [7:0] tgt  = (in_retry & cancel_pend) ? first_avail : hit;
  wire [7:0] next_even = issue & ~odd ? tgt : 8'h00;
  wire [7:0] next_odd  = issue &  odd ? tgt : 8'h00;
  wire acc_hit    = |(accept_s & sel_mask);
  wire done       = in_wait & acc_hit;
  wire [7:0] grant_pick = lowest_one({4'h0, csync_s});

  // Next state of the request sequence.
  always_comb begin
    next_st = st;
    case (st)
      ssp_pkg::S_IDLE: begin
        if (cpu_req | chan_req) begin
          next_st = ssp_pkg::S_DECODE;
        end
      end
      ssp_pkg::S_DECODE: begin
        // A withheld or refused first try costs one more cycle.
        next_st = (det_any | req_bad) ? ssp_pkg::S_RETRY : ssp_pkg::S_WAIT;
      end
      ssp_pkg::S_RETRY: begin
        next_st = ssp_pkg::S_WAIT;
      end
      ssp_pkg::S_WAIT: begin
        // Busy units still get select; only accept moves on.
        if (acc_hit) begin
          next_st = ssp_pkg::S_CLEAN;
        end
      end
      ssp_pkg::S_CLEAN: begin
        next_st = ssp_pkg::S_IDLE;
      end
      default: begin
        next_st = ssp_pkg::S_IDLE;
      end
    endcase
  end

  // Request capture, sequencing and relocation latches.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= ssp_pkg::S_IDLE;
      chan_pri <= 1'b0;
      cpu_q <= 24'h000000;
      chan_q <= 24'h000000;
      fwd <= 1'b0;
      bwd <= 1'b0;
      any_reloc <= 1'b0;
      cancel_pend <= 1'b0;
    end else begin
      st <= next_st;
      if (st == ssp_pkg::S_IDLE) begin
        chan_pri <= chan_req;
        cpu_q <= cpu_or;
        chan_q <= chan_addr;
      end
      if (in_dec) begin
        fwd <= det_fwd;
        bwd <= det_bwd & ~det_fwd;
        any_reloc <= det_any;
        cancel_pend <= ~det_any & req_bad;
      end else if (st == ssp_pkg::S_CLEAN) begin
        fwd <= 1'b0;
        bwd <= 1'b0;
        any_reloc <= 1'b0;
        cancel_pend <= 1'b0;
      end
    end
  end

  // Selection outputs are single-cycle pulses.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_even <= 8'h00;
      select_odd <= 8'h00;
      select_cancel <= 1'b0;
      sel_mask <= 8'h00;
      storage_address_bus <= 24'h000000;
    end else begin
      select_even <= next_even;
      select_odd <= next_odd;
      select_cancel <= in_retry & cancel_pend;
      if (issue) begin
        sel_mask <= tgt;
        storage_address_bus <= comb_addr;
      end
    end
  end

  // Clock stopping, cleanup and timed accept.
  // The accept input is resynchronised, so even an idle unit reaches
  // this logic two cycles late and the inhibit normally rises once.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_first <= 1'b0;
      osc_inhibit <= 1'b0;
      cpu_clock_stop <= 1'b0;
      bus_cleanup <= 1'b0;
      acc_dly <= '0;
      chan_grant <= 4'h0;
    end else begin
      wait_first <= issue;
      if (done) begin
        osc_inhibit <= 1'b0;
      end else if (in_wait & wait_first) begin
        osc_inhibit <= 1'b1;
      end
      cpu_clock_stop <= in_dec & det_any & ~chan_pri;
      bus_cleanup <= done;
      acc_dly <= {acc_dly[ssp_pkg::ACC_DELAY_CYC-2:0], done};
      chan_grant <= acc_dly[ssp_pkg::ACC_DELAY_CYC-1]
                    ? grant_pick[ssp_pkg::CHANS-1:0] : 4'h0;
    end
  end

  // ************************************************************
  // Register slave
  // ************************************************************
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic        w_lane0;
  wire         wr_go  = aw_held & w_held & ~s_axi_bvalid;
  wire         wr_ctl = wr_go & (aw_q == ssp_pkg::OFF_CTRL) & w_lane0;
  wire         wr_ok  = (aw_q == ssp_pkg::OFF_CTRL);
  wire         load   = wr_ctl & (w_q[ssp_pkg::CTRL_LOAD]
                                 | w_q[ssp_pkg::CTRL_RESTART]);
  wire [31:0]  stat_w = {24'h0, ~(st == ssp_pkg::S_IDLE), select_cancel,
                         osc_inhibit, bad_cfg, any_reloc, bwd, fwd,
                         enable_prefix};
  wire [31:0]  rd_val = (s_axi_araddr == ssp_pkg::OFF_CTRL) ? {30'h0, ctrl}
                      : (s_axi_araddr == ssp_pkg::OFF_STAT) ? stat_w
                      : {8'h0, storage_address_bus};
  wire         rd_ok  = (s_axi_araddr == ssp_pkg::OFF_CTRL)
                      | (s_axi_araddr == ssp_pkg::OFF_STAT)
                      | (s_axi_araddr == ssp_pkg::OFF_ADDR);

  // Write channel: address and data may come in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ssp_pkg::RESP_OKAY;
      ctrl <= ssp_pkg::CTRL_RESET;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_q <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (wr_ctl) begin
        ctrl <= w_q[1:0];
      end
    end
  end

  // The prefix switch is sampled at power on, load and restart.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_done <= 1'b0;
      enable_prefix <= 1'b0;
    end else begin
      pwr_done <= 1'b1;
      if (!pwr_done) begin
        enable_prefix <= ctrl[ssp_pkg::CTRL_PREFIX_SW];
      end else if (load) begin
        enable_prefix <= w_q[ssp_pkg::CTRL_PREFIX_SW];
      end
    end
  end

  // Read channel: one outstanding read, answered the next cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= ssp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_val : 32'h0;
      s_axi_rresp <= rd_ok ? ssp_pkg::RESP_OKAY : ssp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_select_avail_only: assert property (
    !select_cancel |-> ((select_even | select_odd) & ~$past(avail)) == 8'h00)
    else $error("select sent to an unavailable unit");
  a_withheld_pulse: assert property (
    in_dec && det_any |=> (select_even | select_odd) == 8'h00 && any_reloc)
    else $error("first pulse not withheld on prefix detect");
  a_fwd_address: assert property (
    fwd && in_retry |-> ufield == fpref_s
      && (comb_addr & ssp_pkg::FWD_ONES) == ssp_pkg::FWD_ONES)
    else $error("forward relocation address wrong");
  a_bwd_zero: assert property (
    bwd |-> !chan_pri && (comb_addr & ssp_pkg::BLK_MASK) == 24'h0)
    else $error("backward relocation did not clear bits 0-11");
  a_cancel_target: assert property (
    select_cancel |-> (select_even | select_odd) == $past(first_avail))
    else $error("cancel not sent to first powered unit");
  a_reloc_no_cancel: assert property (
    select_cancel |-> !any_reloc)
    else $error("cancel raised on a relocation retry");
  a_inhibit_hold: assert property (
    osc_inhibit && in_wait && !acc_hit |=> osc_inhibit)
    else $error("inhibit dropped before accept");
  a_cleanup_cause: assert property (
    bus_cleanup |-> $past(done) && !osc_inhibit)
    else $error("cleanup without accept");
  a_timed_accept: assert property (
    done ##1 (csync_s == 4'h1)[*3] |=> chan_grant == 4'h1)
    else $error("timed accept grant missing");
  a_cpu_stop_one: assert property (
    cpu_clock_stop |-> !chan_pri ##1 !cpu_clock_stop)
    else $error("processor clock stop not one cycle");
  a_high_invalid: assert property (
    in_dec && hi_bits && !det_any |=> in_retry ##1 select_cancel)
    else $error("high address not cancelled");
  a_reloc_clear: assert property (
    bus_cleanup |=> !fwd && !bwd && !any_reloc)
    else $error("relocation state left after cleanup");

  c_forward_done: cover property (fwd && bus_cleanup);
  c_cancel_seen: cover property (select_cancel);
  c_inhibit_seen: cover property ($rose(osc_inhibit));
  c_chan_grant: cover property (chan_grant != 4'h0);

endmodule

// ==== bench/ssp_store_model.sv ====
/*
  Storage unit model: each unit answers a select with a two-cycle accept.
  Assumes one-cycle select pulses from the block under test.
*/
`timescale 1ns/1ps
module ssp_store_model (
  input  wire logic       aclk,
  input  wire logic [7:0] sel,
  input  wire logic       slow,
  output logic [7:0]      unit_accept
);
  logic [7:0] pipe [0:7];
  // A busy unit records the select and answers later.
  always_ff @(posedge aclk) begin
    pipe[0] <= sel;
    for (int k = 1; k < 8; k++) pipe[k] <= pipe[k-1];
  end
  assign unit_accept = slow ? (pipe[5] | pipe[6])
                            : (pipe[0] | pipe[1]);
endmodule

// ==== bench/tb.sv ====
/*
  Self-checking bench for the storage select block.
  Assumes unit i carries floating code i and all units are available, except unit 3 while it is in test for one request.
*/
`timescale 1ns/1ps
module tb;
  logic aclk = 0, aresetn = 0, slow = 0, stop_seen = 0, inh_seen = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, cpu_req = 0, chan_req = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, select_cancel, osc_inhibit, cpu_clock_stop, bus_cleanup;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, unit_accept;
  logic [7:0] unit_alloc = 8'hff, unit_power = 8'hff, unit_test = 0;
  logic [7:0] select_even, select_odd;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf, chan_sync = 0, chan_grant, grant_seen = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] cpu_gate = 3'h1, float_prefix = 3'h7;
  logic [23:0] cpu_src_data = 0, chan_addr = 0, storage_address_bus;
  logic [23:0] instruction_counter_source = 0, alternate_address_source = 0;
  logic [23:0] unit_code = 24'hfac688;
  logic [4:0][2:0] unused_dummy_never = '0;
  logic dup_detect = 0;
  int n_errors = 0, check_count = 0, n_stop = 0;
  ssp_select i_ssp_select (.*);
  ssp_store_model i_ssp_store_model (.aclk(aclk), .slow(slow),
    .sel(select_even | select_odd), .unit_accept(unit_accept));
  initial forever #5 aclk = ~aclk;
  // Sticky monitors, so short pulses are never missed.
  always @(posedge aclk) begin
    if (cpu_clock_stop === 1'b1) stop_seen <= 1;
    if (osc_inhibit === 1'b1) inh_seen <= 1;
    if (cpu_clock_stop === 1'b1) n_stop <= n_stop + 1;
    if (chan_grant !== 4'h0) grant_seen <= chan_grant;
  end
  task complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [31:0] v);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= 8'h00; s_axi_wdata <= v; s_axi_awvalid <= 1;
    s_axi_wvalid <= 1; s_axi_bready <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 0;
    if (i == 20) begin n_errors++; complete_run; end
  endtask
  task rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
    if (i == 20) begin n_errors++; complete_run; end
  endtask
  // One request; selects are gathered until cleanup, then judged.
  task req(input logic ch, input logic [23:0] a, input logic [15:0] es,
           input logic ec, input logic [23:0] eb);
    int i;
    logic [15:0] s;
    logic c;
    s = 0; c = 0;
    @(posedge aclk);
    cpu_req <= !ch; chan_req <= ch; cpu_src_data <= a; chan_addr <= a;
    @(posedge aclk);
    cpu_req <= 0; chan_req <= 0;
    for (i = 0; i < 60 && bus_cleanup !== 1'b1; i++) begin
      @(posedge aclk); #1;
      s = s | {select_odd, select_even}; c = c | select_cancel;
    end
    if (i == 60) begin n_errors++; complete_run; end
    chk(s, es);
    chk(c, ec);
    if (!ec) chk(storage_address_bus, eb);
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    repeat (4) @(posedge aclk);
    rd(8'h04);
    chk(d, 32'h10);
    wr(32'h6);
    chan_sync <= 4'h3;
    req(0, 24'h040000, 16'h0002, 0, 24'h040000);
    req(0, 24'h040008, 16'h0200, 0, 24'h040008);
    chk(grant_seen, 4'h1);
    chan_sync <= 4'h1;
    slow <= 1;
    req(0, 24'h080000, 16'h0004, 0, 24'h080000);
    chk(inh_seen, 1);
    slow <= 0;
    req(0, 24'h200000, 16'h0001, 1, 0);
    unit_test <= 8'h08;
    req(0, 24'h0c0000, 16'h0001, 1, 0);
    unit_test <= 8'h00;
    chk(stop_seen, 0);
    wr(32'h7);
    req(0, 24'h000010, 16'h8000, 0, 24'h1ff010);
    chk(stop_seen, 1);
    req(1, 24'h000020, 16'h8000, 0, 24'h1ff020);
    chk(n_stop, 1);
    req(0, 24'h1ff010, 16'h0001, 0, 24'h000010);
    chk(n_stop, 2);
    rd(8'h08);
    chk(d, 32'h000010);
    rd(8'h04);
    chk(d, 32'h1);
    rd(8'h0c);
    chk(r, 2'h2);
    complete_run;
  end
endmodule
